// File: design/nvs_pkg.sv
// nvs_pkg: constants and types shared by the nvm command sequencer.
// assumes an APB slave with 32-bit data and a same-clock flash array port.
package nvs_pkg;

    // apb byte offsets
    localparam logic [7:0] STATUS_OFS   = 8'h00;
    localparam logic [7:0] INDEX_OFS    = 8'h04;
    localparam logic [7:0] PARAM_HI_OFS = 8'h08;
    localparam logic [7:0] PARAM_LO_OFS = 8'h0C;
    localparam logic [7:0] CONFIG_OFS   = 8'h10;

    // nvm_status_reg field positions
    localparam int CMD_COMPLETE_FLAG_BIT   = 7;
    localparam int ACCESS_ERROR_FLAG_BIT = 5;
    localparam int PVIOL_BIT  = 4;
    localparam int VANY_BIT   = 1;
    localparam int VUNC_BIT   = 0;

    // config register field positions
    localparam int ALLOW_EVS_BIT = 0;
    localparam int ALLOW_RO_BIT  = 1;
    localparam int ALLOW_PGM_BIT = 2;
    localparam int PROT_EN_BIT   = 3;
    localparam int PROT_BASE_LSB = 16;

    // reset values
    localparam logic [2:0]  INDEX_RST     = 3'h0;
    localparam logic [15:0] PARAM_RST     = 16'h0000;
    localparam logic [3:0]  CONFIG_RST    = 4'h7;
    localparam logic [15:0] PROT_BASE_RST = 16'hFFFF;

    // command codes
    localparam logic [7:0] CMD_ERASE_VERIFY_SECTION = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE            = 8'h04;
    localparam logic [7:0] CMD_PROGRAM              = 8'h06;

    // parameter slot indices
    localparam logic [2:0] SLOT_EVS_LAUNCH = 3'h2;
    localparam logic [2:0] SLOT_RO_LAUNCH  = 3'h1;
    localparam logic [2:0] SLOT_PGM_ONE    = 3'h3;
    localparam logic [2:0] SLOT_PGM_TWO    = 3'h5;
    localparam logic [2:0] SLOT_LAST       = 3'h5;
    localparam int         SLOT_COUNT      = 6;

    // memory map: bit 23 selects eeprom, flash block size in bytes
    localparam int          ADDR_SEL_BIT   = 23;
    localparam logic [24:0] FLASH_BYTES    = 25'h0001000;
    localparam logic [15:0] OTP_PHRASE_MAX = 16'h0007;
    localparam logic [31:0] ERASED_WORD    = 32'hFFFFFFFF;

    // flash array operations
    localparam logic [1:0] FL_OP_READ = 2'h0;
    localparam logic [1:0] FL_OP_PROG = 2'h1;
    localparam logic [1:0] FL_OP_OTP  = 2'h2;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_EVS,
        CMD_RO,
        CMD_PGM
    } nvs_cmd_e;

    typedef enum logic {
        ST_IDLE,
        ST_REQ
    } nvs_state_e;

endpackage

// File: design/nvs_sequencer.sv
// nvs_sequencer: apb-programmed command sequencer for erase-verify section,
// read-once and program longword commands.
// assumes the flash array shares core_clk and answers each request with fl_ack.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps

module nvs_sequencer (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fl_req,
    output logic      [1:0]  fl_op,
    output logic      [23:0] fl_addr,
    output logic      [31:0] fl_wdata,
    input  wire logic        fl_ack,
    input  wire logic [31:0] fl_rdata,
    input  wire logic        fl_err,
    input  wire logic        fl_uncorr,
    output logic             flash_read_invalid,
    output logic             cmd_busy
);

    nvs_pkg::nvs_state_e state_q;
    nvs_pkg::nvs_cmd_e   cmd_q;
    logic                cmd_complete_flag_q;
    logic                access_error_flag_q;
    logic                protection_violation_flag_q;
    logic [1:0]          verify_status_bits_q;
    logic [2:0]          param_slot_index_q;
    logic [15:0]         command_param_regs_q [nvs_pkg::SLOT_COUNT];
    logic [3:0]          config_q;
    logic [15:0]         prot_base_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;
    logic [23:0]         addr_q;
    logic [31:0]         wdata_q;
    logic [1:0]          op_q;
    logic [15:0]         remain_q;
    logic                lw_q;
    logic                last_lw_q;
    logic                verify_phase_q;

    logic                setup;
    logic                wr_access;
    logic                addr_hit;
    logic                launch_req;
    logic                launch;
    logic [7:0]          code;
    logic [23:0]         gaddr;
    logic [24:0]         range_end;
    logic                addr_valid;
    logic                addr_misaligned;
    logic                addr_protected;
    logic                launch_access_error_flag;
    logic                launch_pviol;
    nvs_pkg::nvs_cmd_e   launch_cmd;
    logic                step_done;
    logic                last_step;
    logic                blank_fail;
    logic                verify_fail;

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign pready    = psel && penable;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;

    always_comb begin
        case (paddr)
            nvs_pkg::STATUS_OFS,
            nvs_pkg::INDEX_OFS,
            nvs_pkg::PARAM_HI_OFS,
            nvs_pkg::PARAM_LO_OFS,
            nvs_pkg::CONFIG_OFS: addr_hit = 1'b1;
            default:             addr_hit = 1'b0;
        endcase
    end

    // launch is writing one to the complete flag while it is set
    assign launch_req = wr_access && (paddr == nvs_pkg::STATUS_OFS) && pwdata[nvs_pkg::CMD_COMPLETE_FLAG_BIT]
                        && cmd_complete_flag_q;
    // a launch with stale error flags pending is ignored
    assign launch     = launch_req && !access_error_flag_q && !protection_violation_flag_q
                        && !pwdata[nvs_pkg::ACCESS_ERROR_FLAG_BIT] && !pwdata[nvs_pkg::PVIOL_BIT];

    assign code      = command_param_regs_q[0][15:8];
    assign gaddr     = {command_param_regs_q[0][7:0], command_param_regs_q[1]};
    // bit 23 set means eeprom, never a flash target
    assign addr_valid      = !gaddr[nvs_pkg::ADDR_SEL_BIT]
                             && ({2'b00, gaddr[22:0]} < nvs_pkg::FLASH_BYTES);
    assign addr_misaligned = (gaddr[1:0] != 2'b00);
    assign addr_protected  = config_q[nvs_pkg::PROT_EN_BIT] && (gaddr[22:0] >= {7'h00, prot_base_q});

    always_comb begin
        range_end = {2'b00, gaddr[22:0]};
        case (code)
            nvs_pkg::CMD_ERASE_VERIFY_SECTION:
                range_end = {2'b00, gaddr[22:0]} + {7'h00, command_param_regs_q[2], 2'b00};
            nvs_pkg::CMD_PROGRAM:
                range_end = {2'b00, gaddr[22:0]}
                            + ((param_slot_index_q == nvs_pkg::SLOT_PGM_TWO) ? 25'h0000008 : 25'h0000004);
            default:
                range_end = {2'b00, gaddr[22:0]};
        endcase
    end

    // launch checks, each sets the access error (protection sets the violation flag) and stops the command
    always_comb begin
        launch_access_error_flag = 1'b0;
        launch_pviol  = 1'b0;
        launch_cmd    = nvs_pkg::CMD_NONE;
        case (code)
            nvs_pkg::CMD_ERASE_VERIFY_SECTION: begin
                launch_cmd = nvs_pkg::CMD_EVS;
                if (param_slot_index_q != nvs_pkg::SLOT_EVS_LAUNCH) launch_access_error_flag = 1'b1;
                if (!config_q[nvs_pkg::ALLOW_EVS_BIT]) launch_access_error_flag = 1'b1;
                if (addr_misaligned) launch_access_error_flag = 1'b1;
                if (!addr_valid) launch_access_error_flag = 1'b1;
                // zero count treated as an empty, illegal section
                if (command_param_regs_q[2] == 16'h0000
                    || range_end > nvs_pkg::FLASH_BYTES) launch_access_error_flag = 1'b1;
            end
            nvs_pkg::CMD_READ_ONCE: begin
                launch_cmd = nvs_pkg::CMD_RO;
                if (param_slot_index_q != nvs_pkg::SLOT_RO_LAUNCH) launch_access_error_flag = 1'b1;
                if (!config_q[nvs_pkg::ALLOW_RO_BIT]) launch_access_error_flag = 1'b1;
                if (command_param_regs_q[1] > nvs_pkg::OTP_PHRASE_MAX) launch_access_error_flag = 1'b1;
            end
            nvs_pkg::CMD_PROGRAM: begin
                launch_cmd = nvs_pkg::CMD_PGM;
                if (param_slot_index_q != nvs_pkg::SLOT_PGM_ONE
                    && param_slot_index_q != nvs_pkg::SLOT_PGM_TWO) launch_access_error_flag = 1'b1;
                if (!config_q[nvs_pkg::ALLOW_PGM_BIT]) launch_access_error_flag = 1'b1;
                if (addr_misaligned) launch_access_error_flag = 1'b1;
                if (!addr_valid) launch_access_error_flag = 1'b1;
                if (range_end > nvs_pkg::FLASH_BYTES) launch_access_error_flag = 1'b1;
                // protection only reported for an otherwise legal program
                launch_pviol = !launch_access_error_flag && addr_protected;
            end
            default: launch_access_error_flag = 1'b1;
        endcase
    end

    assign step_done = (state_q == nvs_pkg::ST_REQ) && fl_ack;

    always_comb begin
        case (cmd_q)
            nvs_pkg::CMD_EVS: last_step = (remain_q == 16'h0001);
            nvs_pkg::CMD_RO:  last_step = lw_q;
            nvs_pkg::CMD_PGM: last_step = verify_phase_q && (lw_q == last_lw_q);
            default:          last_step = 1'b1;
        endcase
    end

    assign blank_fail  = (cmd_q == nvs_pkg::CMD_EVS) && (fl_rdata != nvs_pkg::ERASED_WORD);
    assign verify_fail = (cmd_q == nvs_pkg::CMD_PGM) && verify_phase_q && (fl_rdata != wdata_q);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= nvs_pkg::ST_IDLE;
            cmd_q   <= nvs_pkg::CMD_NONE;
        end else begin
            case (state_q)
                nvs_pkg::ST_IDLE: begin
                    if (launch && !launch_access_error_flag && !launch_pviol) begin
                        state_q <= nvs_pkg::ST_REQ;
                        cmd_q   <= launch_cmd;
                    end
                end
                nvs_pkg::ST_REQ: begin
                    if (step_done && last_step) begin
                        state_q <= nvs_pkg::ST_IDLE;
                    end
                end
                default: state_q <= nvs_pkg::ST_IDLE;
            endcase
        end
    end

    // complete flag low from launch until the last flash answer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_complete_flag_q <= 1'b1;
        end else if (launch && !launch_access_error_flag && !launch_pviol) begin
            cmd_complete_flag_q <= 1'b0;
        end else if (step_done && last_step) begin
            cmd_complete_flag_q <= 1'b1;
        end
    end

    // error flags are write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            access_error_flag_q         <= 1'b0;
            protection_violation_flag_q <= 1'b0;
        end else begin
            if (launch && launch_access_error_flag) begin
                access_error_flag_q <= 1'b1;
            end else if (wr_access && paddr == nvs_pkg::STATUS_OFS && pwdata[nvs_pkg::ACCESS_ERROR_FLAG_BIT]) begin
                access_error_flag_q <= 1'b0;
            end
            if (launch && launch_pviol) begin
                protection_violation_flag_q <= 1'b1;
            end else if (wr_access && paddr == nvs_pkg::STATUS_OFS && pwdata[nvs_pkg::PVIOL_BIT]) begin
                protection_violation_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            verify_status_bits_q <= 2'b00;
        end else if (launch) begin
            verify_status_bits_q <= 2'b00;
        end else if (step_done) begin
            if (blank_fail) begin
                verify_status_bits_q <= 2'b11;
            end else begin
                if (fl_err || fl_uncorr || verify_fail) verify_status_bits_q[nvs_pkg::VANY_BIT] <= 1'b1;
                if (fl_uncorr) verify_status_bits_q[nvs_pkg::VUNC_BIT] <= 1'b1;
            end
        end
    end

    // index and parameters take no bus writes while a command runs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            param_slot_index_q <= nvs_pkg::INDEX_RST;
        end else if (wr_access && paddr == nvs_pkg::INDEX_OFS && cmd_complete_flag_q) begin
            param_slot_index_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < nvs_pkg::SLOT_COUNT; i++) begin
                command_param_regs_q[i] <= nvs_pkg::PARAM_RST;
            end
        end else if (step_done && cmd_q == nvs_pkg::CMD_RO) begin
            // phrase longword lands in slots 2-3 or 4-5
            command_param_regs_q[{1'b0, lw_q, 1'b0} + 3'h2] <= fl_rdata[31:16];
            command_param_regs_q[{1'b0, lw_q, 1'b0} + 3'h3] <= fl_rdata[15:0];
        end else if (wr_access && cmd_complete_flag_q && param_slot_index_q <= nvs_pkg::SLOT_LAST) begin
            if (paddr == nvs_pkg::PARAM_HI_OFS) begin
                command_param_regs_q[param_slot_index_q][15:8] <= pwdata[7:0];
            end else if (paddr == nvs_pkg::PARAM_LO_OFS) begin
                command_param_regs_q[param_slot_index_q][7:0] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            config_q    <= nvs_pkg::CONFIG_RST;
            prot_base_q <= nvs_pkg::PROT_BASE_RST;
        end else if (wr_access && paddr == nvs_pkg::CONFIG_OFS && cmd_complete_flag_q) begin
            config_q    <= pwdata[3:0];
            prot_base_q <= pwdata[nvs_pkg::PROT_BASE_LSB +: 16];
        end
    end

    // flash request sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_q         <= 24'h000000;
            wdata_q        <= 32'h00000000;
            op_q           <= nvs_pkg::FL_OP_READ;
            remain_q       <= 16'h0000;
            lw_q           <= 1'b0;
            last_lw_q      <= 1'b0;
            verify_phase_q <= 1'b0;
        end else if (state_q == nvs_pkg::ST_IDLE) begin
            lw_q           <= 1'b0;
            verify_phase_q <= 1'b0;
            remain_q       <= command_param_regs_q[2];
            last_lw_q      <= (param_slot_index_q == nvs_pkg::SLOT_PGM_TWO);
            wdata_q        <= {command_param_regs_q[2], command_param_regs_q[3]};
            case (code)
                nvs_pkg::CMD_READ_ONCE: begin
                    op_q   <= nvs_pkg::FL_OP_OTP;
                    addr_q <= {18'h00000, command_param_regs_q[1][2:0], 3'h0};
                end
                nvs_pkg::CMD_PROGRAM: begin
                    op_q   <= nvs_pkg::FL_OP_PROG;
                    addr_q <= gaddr;
                end
                default: begin
                    op_q   <= nvs_pkg::FL_OP_READ;
                    addr_q <= gaddr;
                end
            endcase
        end else if (step_done) begin
            case (cmd_q)
                nvs_pkg::CMD_EVS: begin
                    addr_q   <= addr_q + 24'h000004;
                    remain_q <= remain_q - 16'h0001;
                end
                nvs_pkg::CMD_RO: begin
                    lw_q   <= 1'b1;
                    addr_q <= addr_q + 24'h000004;
                end
                nvs_pkg::CMD_PGM: begin
                    // program then read back the same longword
                    if (!verify_phase_q) begin
                        verify_phase_q <= 1'b1;
                        op_q           <= nvs_pkg::FL_OP_READ;
                    end else begin
                        verify_phase_q <= 1'b0;
                        op_q           <= nvs_pkg::FL_OP_PROG;
                        lw_q           <= 1'b1;
                        addr_q         <= addr_q + 24'h000004;
                        wdata_q        <= {command_param_regs_q[4], command_param_regs_q[5]};
                    end
                end
                default: op_q <= nvs_pkg::FL_OP_READ;
            endcase
        end
    end

    assign fl_req   = (state_q == nvs_pkg::ST_REQ);
    assign fl_op    = op_q;
    assign fl_addr  = addr_q;
    assign fl_wdata = wdata_q;
    assign cmd_busy = !cmd_complete_flag_q;
    // ordinary fetches from flash give garbage during read-once
    assign flash_read_invalid = (state_q == nvs_pkg::ST_REQ) && (cmd_q == nvs_pkg::CMD_RO);

    // read data captured in the setup cycle, answered with no wait states
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !addr_hit;
            prdata_q  <= 32'h00000000;
            case (paddr)
                nvs_pkg::STATUS_OFS: begin
                    prdata_q[nvs_pkg::CMD_COMPLETE_FLAG_BIT]   <= cmd_complete_flag_q;
                    prdata_q[nvs_pkg::ACCESS_ERROR_FLAG_BIT] <= access_error_flag_q;
                    prdata_q[nvs_pkg::PVIOL_BIT]  <= protection_violation_flag_q;
                    prdata_q[1:0]                 <= verify_status_bits_q;
                end
                nvs_pkg::INDEX_OFS: prdata_q[2:0] <= param_slot_index_q;
                nvs_pkg::PARAM_HI_OFS: begin
                    if (param_slot_index_q <= nvs_pkg::SLOT_LAST) begin
                        prdata_q[7:0] <= command_param_regs_q[param_slot_index_q][15:8];
                    end
                end
                nvs_pkg::PARAM_LO_OFS: begin
                    if (param_slot_index_q <= nvs_pkg::SLOT_LAST) begin
                        prdata_q[7:0] <= command_param_regs_q[param_slot_index_q][7:0];
                    end
                end
                nvs_pkg::CONFIG_OFS: begin
                    prdata_q[3:0]                         <= config_q;
                    prdata_q[nvs_pkg::PROT_BASE_LSB +: 16] <= prot_base_q;
                end
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

endmodule

// File: testbench/nvs_flash_model.sv
// nvs_flash_model: behavioural flash array with a fixed one-time field.
// assumes requests are held until ack; slow adds wait cycles, bad injects errors.
`timescale 1ns/10ps
module nvs_flash_model (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        fl_req,
    input wire logic [1:0]  fl_op,
    input wire logic [23:0] fl_addr,
    input wire logic [31:0] fl_wdata,
    input wire logic [3:0]  slow,
    input wire logic [1:0]  bad,
    output logic            fl_ack,
    output logic [31:0]     fl_rdata,
    output logic            fl_err,
    output logic            fl_uncorr
);
    logic [31:0] mem [1024];
    logic [3:0]  cnt;
    initial for (int i = 0; i < 1024; i++) mem[i] = 32'hFFFFFFFF;
    always @(posedge core_clk) begin
        fl_ack <= 1'b0;
        {fl_uncorr, fl_err} <= 2'h0;
        // stale data toggles so it never passes for an answer
        fl_rdata <= reset ? 32'h0 : ~fl_rdata;
        if (reset || fl_ack) cnt <= 4'h0;
        else if (fl_req && cnt < slow) cnt <= cnt + 4'h1;
        else if (fl_req) begin
            fl_ack <= 1'b1;
            // programming only clears bits, as a real cell does
            if (fl_op == nvs_pkg::FL_OP_PROG) mem[fl_addr[11:2]] <= mem[fl_addr[11:2]] & fl_wdata;
            else {fl_uncorr, fl_err} <= bad;
            // one-time field: fixed content, no erase path
            fl_rdata <= fl_op == nvs_pkg::FL_OP_OTP ? {26'h2D0000, fl_addr[5:0]} : mem[fl_addr[11:2]];
        end
    end
endmodule

// File: testbench/nvs_seq_monitor.sv
// nvs_seq_monitor: port assertions for the nvm command sequencer.
// assumes binding to nvs_sequencer, one clock, synchronous reset.
`timescale 1ns/10ps
module nvs_seq_monitor (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        fl_req,
    input wire logic [1:0]  fl_op,
    input wire logic [23:0] fl_addr,
    input wire logic [31:0] fl_wdata,
    input wire logic        fl_ack,
    input wire logic        flash_read_invalid,
    input wire logic        cmd_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic launch;
    assign launch = psel && penable && pwrite && paddr == nvs_pkg::STATUS_OFS && pwdata[nvs_pkg::CMD_COMPLETE_FLAG_BIT];
    a_launch_cause: assert property ($rose(cmd_busy) |-> $past(launch))
        else $error("busy rose without a launch write");
    a_start_req: assert property ($rose(cmd_busy) |-> ##[0:2] fl_req)
        else $error("accepted command issued no flash request");
    a_done_on_ack: assert property ($fell(cmd_busy) && !$past(reset) |-> $past(fl_ack))
        else $error("complete flag set without a flash answer");
    a_req_busy: assert property (fl_req |-> cmd_busy)
        else $error("flash request while complete flag set");
    a_req_hold: assert property (fl_req && !fl_ack |=> fl_req)
        else $error("flash request dropped before ack");
    a_prog_stable: assert property (fl_req && fl_op == nvs_pkg::FL_OP_PROG && !fl_ack
        |=> $stable(fl_addr) && $stable(fl_wdata))
        else $error("program request changed before ack");
    a_prog_verify: assert property (fl_ack && fl_op == nvs_pkg::FL_OP_PROG
        |=> fl_req && fl_op == nvs_pkg::FL_OP_READ)
        else $error("program not followed by readback");
    a_aligned: assert property (fl_req |-> fl_addr[1:0] == 2'h0)
        else $error("flash address not longword aligned");
    a_in_flash: assert property (fl_req && fl_op != nvs_pkg::FL_OP_OTP
        |-> {1'b0, fl_addr} < nvs_pkg::FLASH_BYTES)
        else $error("flash address outside flash block");
    a_otp_field: assert property (fl_req && fl_op == nvs_pkg::FL_OP_OTP
        |-> flash_read_invalid && fl_addr[23:6] == 18'h0)
        else $error("one-time read outside field or reads valid");
    c_launch: cover property ($rose(cmd_busy));
    c_prog: cover property (fl_ack && fl_op == nvs_pkg::FL_OP_PROG);
    c_otp: cover property (fl_ack && fl_op == nvs_pkg::FL_OP_OTP);
endmodule

bind nvs_sequencer nvs_seq_monitor u_mon (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .fl_req, .fl_op, .fl_addr, .fl_wdata, .fl_ack, .flash_read_invalid, .cmd_busy);

// File: testbench/test_nvm_verify_readonce_program_cmds.sv
// test_nvm_verify_readonce_program_cmds: apb-driven checks of the sequencer.
// assumes nvs_sequencer with its flash model and bound monitor.
`timescale 1ns/10ps
module test_nvm_verify_readonce_program_cmds;
    logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, fl_req, fl_ack;
    logic        fl_err, fl_uncorr, flash_read_invalid, cmd_busy, rs;
    logic [7:0]  paddr, hv;
    logic [31:0] pwdata, prdata, fl_wdata, fl_rdata, r, rng, d0, d1;
    logic [23:0] fl_addr, a;
    logic [1:0]  fl_op, bad;
    logic [3:0]  slow;
    logic [15:0] sl [6];
    int          mismatches, n_tests;
    nvs_sequencer dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fl_req, .fl_op, .fl_addr, .fl_wdata, .fl_ack, .fl_rdata, .fl_err, .fl_uncorr,
        .flash_read_invalid, .cmd_busy);
    nvs_flash_model u_fl (.core_clk, .reset, .fl_req, .fl_op, .fl_addr, .fl_wdata, .slow, .bad,
        .fl_ack, .fl_rdata, .fl_err, .fl_uncorr);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        rs = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // loads every slot, launches, waits for completion, then clears error flags
    task automatic cmd(input logic [7:0] c, input logic [23:0] ad, input logic [2:0] ix, input logic [7:0] exp);
        sl[0] = {c, ad[23:16]};
        sl[1] = ad[15:0];
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, nvs_pkg::INDEX_OFS, k);
            apb(1'b1, nvs_pkg::PARAM_HI_OFS, sl[k][15:8]);
            apb(1'b1, nvs_pkg::PARAM_LO_OFS, sl[k][7:0]);
        end
        apb(1'b1, nvs_pkg::INDEX_OFS, ix);
        apb(1'b1, nvs_pkg::STATUS_OFS, 32'h80);
        do apb(1'b0, nvs_pkg::STATUS_OFS, 32'h0); while (r[7] !== 1'b1);
        check(r[7:0], exp);
        apb(1'b1, nvs_pkg::STATUS_OFS, 32'h30);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        // twenty thousand cycles is several times the expected run
        #(20000 * 5);
        mismatches++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow, bad} = '0;
        {mismatches, n_tests} = '0;
        reset = 1'b1;
        rng = 32'h69BE;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        check(rs, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            d0 = rng;
            rng = xs(rng);
            d1 = rng;
            {sl[2], sl[3], sl[4], sl[5]} = {d0, d1};
            slow <= rng[3:0];
            a = {12'h000, i[3:0], rng[9:5], 3'h0};
            cmd(nvs_pkg::CMD_PROGRAM, a, i[0] ? nvs_pkg::SLOT_PGM_ONE : nvs_pkg::SLOT_PGM_TWO, 8'h80);
            check(u_fl.mem[a[11:2]], d0);
            check(u_fl.mem[a[11:2] + 1], i[0] ? nvs_pkg::ERASED_WORD : d1);
            sl[2] = 16'h0002;
            cmd(nvs_pkg::CMD_ERASE_VERIFY_SECTION, a, nvs_pkg::SLOT_EVS_LAUNCH, 8'h83);
        end
        sl[2] = 16'h0004;
        cmd(8'h03, 24'h000C00, 3'h2, 8'h80);
        $display("test program and blank check done");
        cmd(8'h03, 24'h000C00, 3'h1, 8'hA0);
        cmd(8'h03, 24'h000C02, 3'h2, 8'hA0);
        cmd(8'h03, 24'h800000, 3'h2, 8'hA0);
        cmd(8'h03, 24'h001000, 3'h2, 8'hA0);
        cmd(8'h03, 24'h000FF8, 3'h2, 8'hA0);
        cmd(8'h06, 24'h000FFC, 3'h5, 8'hA0);
        cmd(8'h06, 24'h000C00, 3'h4, 8'hA0);
        cmd(8'h04, 24'h000000, 3'h2, 8'hA0);
        cmd(8'h05, 24'h000000, 3'h2, 8'hA0);
        cmd(8'h04, 24'h000008, 3'h1, 8'hA0);
        apb(1'b1, nvs_pkg::CONFIG_OFS, 32'h0);
        for (int c = 0; c < 3; c++) cmd(c == 0 ? 8'h03 : c == 1 ? 8'h04 : 8'h06, 24'h000004,
            c == 0 ? 3'h2 : c == 1 ? 3'h1 : 3'h3, 8'hA0);
        apb(1'b1, nvs_pkg::CONFIG_OFS, 32'h0800000F);
        cmd(8'h06, 24'h000900, 3'h3, 8'h90);
        cmd(8'h03, 24'h000900, 3'h2, 8'h80);
        apb(1'b1, nvs_pkg::CONFIG_OFS, 32'h7);
        $display("test launch checks done");
        for (int p = 0; p < 8; p++) begin
            bad <= p == 5 ? 2'h1 : p == 6 ? 2'h3 : 2'h0;
            @(posedge core_clk);
            cmd(8'h04, {21'h0, p[2:0]}, 3'h1, {6'h20, bad[0], bad[1]});
            for (int k = 2; k < 6 && bad == 2'h0; k++) begin
                apb(1'b1, nvs_pkg::INDEX_OFS, k);
                apb(1'b0, nvs_pkg::PARAM_HI_OFS, 32'h0);
                hv = r[7:0];
                apb(1'b0, nvs_pkg::PARAM_LO_OFS, 32'h0);
                d0 = {26'h2D0000, p[2:0], k >= 4, 2'h0};
                check({hv, r[7:0]}, k[0] ? d0[15:0] : d0[31:16]);
            end
        end
        $display("test read-once done");
        conclude();
    end
endmodule
